// >>> verilog/otpc_pkg.sv
// Package of timing constants, commands and pin bundles for the OTP memory controller
package otpc_pkg;
  localparam int CLK_MHZ           = 100;
  // Read timing in ns, slowest grade by default
  localparam int ACC_NS            = 120;
  localparam int GATE_NS           = 40;
  localparam int FLOAT_NS          = 30;
  localparam int PFLOAT_NS         = 130;
  // Programming timing in us
  localparam int SETUP_US          = 2;
  localparam int HOLD_US           = 2;
  localparam int PULSE_US          = 75;
  localparam int ACC_CYC   = (ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int GATE_CYC  = (GATE_NS * CLK_MHZ + 999) / 1000;
  localparam int FLOAT_CYC = (FLOAT_NS * CLK_MHZ + 999) / 1000;
  localparam int PFLT_CYC  = (PFLOAT_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  localparam int HOLD_CYC  = HOLD_US * CLK_MHZ;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int MAX_PULSES        = 25;
  localparam int ADDR_W            = 17;
  localparam logic [16:0] ADDR_LAST = 17'h1_ffff;
  localparam logic [7:0]  BYTE_BLANK = 8'hff;
  localparam int BIT_A9            = 9;
  typedef enum logic [1:0] {
    OTPC_CMD_READ  = 2'h0,
    OTPC_CMD_PROG  = 2'h1,
    OTPC_CMD_IDENT = 2'h2,
    OTPC_CMD_NONE  = 2'h3
  } otpc_cmd_t;
  typedef struct packed {
    logic [16:0] addr;
    logic        id_high_voltage_address_line;
    logic        dev_select_n;
    logic        out_gate_n;
    logic        program_strobe_n;
    logic        vpp_high;
    logic        vcc_high;
  } otpc_pins_t;
endpackage

// >>> verilog/otpc_delay.sv
// Loadable down counter giving a one-cycle done pulse
`timescale 1ns/10ps
module otpc_delay #(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         sys_rst_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);
  logic [W-1:0] cnt;
  logic         run;
  wire          last = run && (cnt == '0);
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      cnt    <= '0;
      run    <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= last && !load_i;
      if (load_i) begin
        cnt <= count_i;
        run <= 1'b1;
      end else if (last) begin
        run <= 1'b0;
      end else if (run) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule

// >>> verilog/otpc_ctrl.sv
// Host-side controller driving the OTP memory pins: read, program and identify
//
// Contract
// - Reading needs select and gate both low.
// - Program mode: high supply, gate high, select and strobe low, byte parallel.
// - Strobe pulse lasts 30 to 105 us, typically 75 us.
// - Pulse then verify each byte, repeat until match or pulse limit.
// - Program at raised core supply, then reread whole array at nominal; the controller drops the supplies after each byte and never rereads.
// - Select high inhibits programming for parts sharing other inputs.
// - Verify: gate and select low, strobe high, supply still raised.
// - Identify: high voltage on line nine, bit one high, step bit zero; the controller takes both bit one and bit zero from the caller.
// - Other address lines held high during identification.
`timescale 1ns/10ps
module otpc_ctrl #(
  parameter int PULSE_CYC  = otpc_pkg::PULSE_CYC,
  parameter int SETUP_CYC  = otpc_pkg::SETUP_CYC,
  parameter int HOLD_CYC   = otpc_pkg::HOLD_CYC,
  parameter int MAX_PULSES = otpc_pkg::MAX_PULSES
) (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  // Command port
  input  wire logic                 cmd_valid_i,
  input  wire otpc_pkg::otpc_cmd_t  cmd_i,
  input  wire logic [16:0]          cmd_addr_i,
  input  wire logic [7:0]           cmd_data_i,
  output logic                      cmd_ready_o,
  output logic                      rsp_valid_o,
  output logic [7:0]                rsp_data_o,
  output logic                      rsp_error_o,
  // Memory pins
  output otpc_pkg::otpc_pins_t      pins_o,
  output logic [7:0]                dq_o,
  output logic                      dq_oe_o,
  input  wire logic [7:0]           dq_i
);
  typedef enum logic [9:0] {
    S_IDLE  = 10'b00_0000_0001,
    S_RACC  = 10'b00_0000_0010,
    S_RDONE = 10'b00_0000_0100,
    S_FLOAT = 10'b00_0000_1000,
    S_PSET  = 10'b00_0001_0000,
    S_PULSE = 10'b00_0010_0000,
    S_PHOLD = 10'b00_0100_0000,
    S_VACC  = 10'b00_1000_0000,
    S_VCHK  = 10'b01_0000_0000,
    S_PFLT  = 10'b10_0000_0000
  } otpc_state_t;

  otpc_state_t state;
  otpc_state_t next_state;
  logic [7:0]  vbyte;
  logic [7:0]  dq_s1;
  logic [7:0]  dq_s2;
  logic [7:0]  wdata;
  logic [7:0]  pulses;
  logic [15:0] dly_count;
  logic        dly_load;
  logic        dly_done;

  // Data pins pass two flops; settle count covers their latency
  always_ff @(posedge ref_clk_i) begin
    dq_s1 <= dq_i;
    dq_s2 <= dq_s1;
  end

  otpc_delay #(.W(16)) u_delay (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (dly_load),
    .count_i   (dly_count),
    .done_o    (dly_done)
  );

  wire take       = (state == S_IDLE) && cmd_valid_i && (cmd_i != otpc_pkg::OTPC_CMD_NONE);
  wire is_prog    = cmd_i == otpc_pkg::OTPC_CMD_PROG;
  wire is_ident   = cmd_i == otpc_pkg::OTPC_CMD_IDENT;
  // BYTE_BLANK masks nothing, so cant_prog never refuses a request; bits already cleared show up at verify
  wire cant_prog  = is_prog && ((cmd_data_i & otpc_pkg::BYTE_BLANK) != cmd_data_i);
  wire verify_ok  = vbyte == wdata;
  wire pulse_lim  = pulses >= 8'(MAX_PULSES);
  // Extra cycles allow the two-flop input stage to settle
  wire [15:0] acc_w  = 16'(otpc_pkg::ACC_CYC + 3);
  wire [15:0] flt_w  = 16'(otpc_pkg::FLOAT_CYC);
  wire [15:0] pflt_w = 16'(otpc_pkg::PFLT_CYC);

  always_comb begin
    next_state = state;
    dly_load   = 1'b0;
    dly_count  = '0;
    case (state)
      S_IDLE: begin
        if (take && !cant_prog) begin
          dly_load   = 1'b1;
          next_state = is_prog ? S_PSET : S_RACC;
          dly_count  = is_prog ? 16'(SETUP_CYC) : acc_w;
        end
      end
      S_RACC:  if (dly_done) next_state = S_RDONE;
      S_RDONE: begin
        next_state = S_FLOAT;
        dly_load   = 1'b1;
        dly_count  = flt_w;
      end
      S_FLOAT: if (dly_done) next_state = S_IDLE;
      S_PSET: begin
        if (dly_done) begin
          next_state = S_PULSE;
          dly_load   = 1'b1;
          // Load and done each cost a cycle, so the pulse comes out exact
          dly_count  = 16'(PULSE_CYC - 2);
        end
      end
      S_PULSE: begin
        if (dly_done) begin
          next_state = S_PHOLD;
          dly_load   = 1'b1;
          dly_count  = 16'(HOLD_CYC);
        end
      end
      S_PHOLD: begin
        if (dly_done) begin
          next_state = S_VACC;
          dly_load   = 1'b1;
          dly_count  = acc_w;
        end
      end
      S_VACC:  if (dly_done) next_state = S_VCHK;
      S_VCHK: begin
        dly_load   = 1'b1;
        next_state = S_PFLT;
        dly_count  = pflt_w;
      end
      S_PFLT: begin
        if (dly_done) begin
          if (!verify_ok && !pulse_lim) begin
            next_state = S_PSET;
            dly_load   = 1'b1;
            dly_count  = 16'(SETUP_CYC);
          end else begin
            next_state = S_IDLE;
          end
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Pin drive, pulse count and response
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pins_o      <= '{addr: '0, id_high_voltage_address_line: 1'b0, dev_select_n: 1'b1,
                       out_gate_n: 1'b1, program_strobe_n: 1'b1, vpp_high: 1'b0,
                       vcc_high: 1'b0};
      dq_o        <= '0;
      dq_oe_o     <= 1'b0;
      wdata       <= '0;
      pulses      <= '0;
      cmd_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= '0;
      rsp_error_o <= 1'b0;
      vbyte       <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      cmd_ready_o <= (next_state == S_IDLE) && !take;
      if (take) begin
        pins_o.addr <= cmd_addr_i;
        wdata       <= cmd_data_i;
        pulses      <= '0;
        if (cant_prog) begin
          rsp_valid_o <= 1'b1;
          rsp_error_o <= 1'b1;
          rsp_data_o  <= '0;
        end else if (is_prog) begin
          // Raised supplies, gate high, select low, data driven
          pins_o.vpp_high     <= 1'b1;
          pins_o.vcc_high     <= 1'b1;
          pins_o.out_gate_n   <= 1'b1;
          pins_o.dev_select_n <= 1'b0;
          dq_o                <= cmd_data_i;
          dq_oe_o             <= 1'b1;
        end else begin
          pins_o.dev_select_n <= 1'b0;
          pins_o.out_gate_n   <= 1'b0;
          pins_o.id_high_voltage_address_line <= is_ident;
          if (is_ident) begin
            // Only bits zero and one are chosen by the caller
            pins_o.addr <= {{(otpc_pkg::ADDR_W - 2){1'b1}}, cmd_addr_i[1:0]};
          end
        end
      end
      case (state)
        S_RACC: if (dly_done) begin
          rsp_data_o  <= dq_s2;
          rsp_error_o <= 1'b0;
          rsp_valid_o <= 1'b1;
        end
        S_RDONE: begin
          pins_o.out_gate_n   <= 1'b1;
          pins_o.dev_select_n <= 1'b1;
          pins_o.id_high_voltage_address_line <= 1'b0;
        end
        S_PSET: if (dly_done) pins_o.program_strobe_n <= 1'b0;
        S_PULSE: if (dly_done) begin
          pins_o.program_strobe_n <= 1'b1;
          pulses                  <= pulses + 1'b1;
        end
        S_PHOLD: if (dly_done) begin
          dq_oe_o           <= 1'b0;
          pins_o.out_gate_n <= 1'b0;
        end
        // Byte kept before the gate rises; a released bus cannot be trusted
        S_VACC: if (dly_done) vbyte <= dq_s2;
        S_VCHK: pins_o.out_gate_n <= 1'b1;
        S_PFLT: if (dly_done) begin
          if (!verify_ok && !pulse_lim) begin
            dq_oe_o <= 1'b1;
          end else begin
            pins_o.vpp_high     <= 1'b0;
            pins_o.vcc_high     <= 1'b0;
            pins_o.dev_select_n <= 1'b1;
            rsp_data_o          <= vbyte;
            rsp_error_o         <= !verify_ok;
            rsp_valid_o         <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end
endmodule

// >>> bench/otpc_monitor.sv
// Concurrent checks on the OTP controller command port and memory pins
`timescale 1ns/10ps
module otpc_monitor #(
  parameter int PULSE_CYC  = 20,
  parameter int SETUP_CYC  = 4,
  parameter int HOLD_CYC   = 4,
  parameter int MAX_PULSES = 3
) (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  // Command port
  input  wire logic                 cmd_valid_i,
  input  wire otpc_pkg::otpc_cmd_t  cmd_i,
  input  wire logic                 cmd_ready_o,
  input  wire logic                 rsp_valid_o,
  // Memory pins
  input  wire otpc_pkg::otpc_pins_t pins_o,
  input  wire logic [7:0]           dq_o,
  input  wire logic                 dq_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire         take   = cmd_valid_i && cmd_ready_o;
  wire         sg_low = !pins_o.dev_select_n && !pins_o.out_gate_n;
  wire         strb   = !pins_o.program_strobe_n;
  logic [31:0] low_cnt;
  logic [31:0] since_rise;
  logic [31:0] stab;
  logic [5:0]  pulses;
  // Counters feed the timing checks; long spans cannot be unrolled
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      low_cnt    <= '0;
      since_rise <= '0;
      stab       <= '0;
      pulses     <= '0;
    end else begin
      low_cnt    <= strb ? low_cnt + 1 : '0;
      since_rise <= strb ? '0 : since_rise + 1;
      stab       <= ($stable(pins_o.addr) && $stable(dq_o) && $stable(pins_o.vpp_high) &&
                     $stable(pins_o.vcc_high) && $stable(pins_o.out_gate_n)) ? stab + 1 : '0;
      pulses     <= take ? '0 : pulses + 6'($fell(pins_o.program_strobe_n));
    end
  end
  sequence sel_low8;
    sg_low [*8];
  endsequence
  prog_mode_a: assert property (strb |-> pins_o.vpp_high && pins_o.vcc_high &&
    pins_o.out_gate_n && !pins_o.dev_select_n && dq_oe_o) else $error("strobe outside program mode");
  pulse_width_a: assert property ($rose(pins_o.program_strobe_n) |-> low_cnt == PULSE_CYC)
    else $error("strobe pulse width wrong");
  setup_time_a: assert property ($fell(pins_o.program_strobe_n) |-> stab >= SETUP_CYC - 1)
    else $error("setup before strobe too short");
  data_hold_a: assert property ($fell(dq_oe_o) |-> since_rise >= HOLD_CYC - 1)
    else $error("data hold after strobe too short");
  verify_gate_a: assert property (!pins_o.out_gate_n |-> pins_o.program_strobe_n &&
    !dq_oe_o && !pins_o.dev_select_n) else $error("gate low in wrong state");
  ident_lines_a: assert property (pins_o.id_high_voltage_address_line |->
    &pins_o.addr[16:10] && &pins_o.addr[8:2] && !pins_o.vpp_high) else $error("identify lines wrong");
  read_wait_a: assert property (take && cmd_i == otpc_pkg::OTPC_CMD_READ |=>
    sel_low8 ##1 sg_low [*4] ##[1:6] rsp_valid_o) else $error("read access too short");
  float_wait_a: assert property ($rose(pins_o.out_gate_n) |-> !cmd_ready_o [*3])
    else $error("ready before output float");
  pulse_limit_a: assert property (pulses <= MAX_PULSES) else $error("too many pulses");
  verify_after_a: assert property ($rose(pins_o.program_strobe_n) |->
    ##[1:400] !pins_o.out_gate_n) else $error("no verify after pulse");
endmodule
bind otpc_ctrl otpc_monitor #(.PULSE_CYC(PULSE_CYC), .SETUP_CYC(SETUP_CYC), .HOLD_CYC(HOLD_CYC),
  .MAX_PULSES(MAX_PULSES)) mon (.ref_clk_i, .sys_rst_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
  .rsp_valid_o, .pins_o, .dq_o, .dq_oe_o);

// >>> bench/otpc_mem_model.sv
// Behavioural model of the OTP memory device behind the controller pins
`timescale 1ns/10ps
module otpc_mem_model #(
  parameter logic [7:0] MAKER_ID = 8'h2a, // Arbitrary value, odd parity
  parameter logic [7:0] TYPE_ID  = 8'h83, // Arbitrary value, odd parity
  parameter logic [7:0] CONT_ID  = 8'h0e  // Arbitrary value
) (
  // Device pins
  input  wire otpc_pkg::otpc_pins_t pins_i,
  input  wire logic [7:0]           dq_i,
  input  wire logic                 dq_oe_i,
  output logic [7:0]                dq_o
);
  logic [7:0] mem [0:131071];
  logic       slow_armed;
  wire        on = !pins_i.dev_select_n && !pins_i.out_gate_n;
  function automatic logic [7:0] rd_val();
    // Released bus flips, so a stale value never passes
    if (!on) return ~dq_o;
    if (pins_i.id_high_voltage_address_line)
      return !pins_i.addr[1] ? CONT_ID : pins_i.addr[0] ? TYPE_ID : MAKER_ID;
    return mem[pins_i.addr];
  endfunction
  initial begin
    dq_o = 8'h00;
    slow_armed = 1'b0;
    foreach (mem[i]) mem[i] = 8'hff;
  end
  // Slowest grade for every access path
  always @(pins_i, dq_i) dq_o <= #(on ? otpc_pkg::ACC_NS : otpc_pkg::FLOAT_NS) rd_val();
  // Odd addresses need a second pulse, to exercise the retry loop
  always @(posedge pins_i.program_strobe_n or posedge pins_i.dev_select_n) begin
    if (pins_i.dev_select_n) begin
      slow_armed <= 1'b0;
    end else if (pins_i.out_gate_n && pins_i.vpp_high && dq_oe_i) begin
      slow_armed <= !slow_armed && pins_i.addr[0];
      if (!pins_i.addr[0] || slow_armed) mem[pins_i.addr] <= mem[pins_i.addr] & dq_i;
    end
  end
endmodule

// >>> bench/otpc_ctrl_tb.sv
// Random and corner-case testbench for the OTP memory controller
`timescale 1ns/10ps
module otpc_ctrl_tb;
  localparam logic [7:0] MAKER = 8'h2a; // Arbitrary value
  localparam logic [7:0] TYPEB = 8'h83; // Arbitrary value
  localparam logic [7:0] CONT  = 8'h0e; // Arbitrary value
  logic                 ref_clk_i;
  logic                 sys_rst_i;
  logic                 cmd_valid_i;
  otpc_pkg::otpc_cmd_t  cmd_i;
  logic [16:0]          cmd_addr_i;
  logic [7:0]           cmd_data_i;
  logic                 cmd_ready_o;
  logic                 rsp_valid_o;
  logic [7:0]           rsp_data_o;
  logic                 rsp_error_o;
  otpc_pkg::otpc_pins_t pins_o;
  logic [7:0]           dq_o;
  logic                 dq_oe_o;
  logic [7:0]           dq_i;
  int                   bad_count;
  int                   num_checks;
  logic [7:0]           shadow [logic [16:0]];
  otpc_ctrl #(.PULSE_CYC(20), .SETUP_CYC(4), .HOLD_CYC(4), .MAX_PULSES(3)) uut (.ref_clk_i,
    .sys_rst_i, .cmd_valid_i, .cmd_i, .cmd_addr_i, .cmd_data_i, .cmd_ready_o, .rsp_valid_o,
    .rsp_data_o, .rsp_error_o, .pins_o, .dq_o, .dq_oe_o, .dq_i);
  otpc_mem_model #(.MAKER_ID(MAKER), .TYPE_ID(TYPEB), .CONT_ID(CONT)) dev (.pins_i(pins_o),
    .dq_i(dq_o), .dq_oe_i(dq_oe_o), .dq_o(dq_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_cmd(input otpc_pkg::otpc_cmd_t c, input logic [16:0] a, input logic [7:0] d,
                        output logic [8:0] r);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 500) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    if (n >= 500) begin
      bad_count++;
      $display("ready timeout at %0t", $time);
    end
    cmd_i       = c;
    cmd_addr_i  = a;
    cmd_data_i  = d;
    cmd_valid_i = 1'b1;
    @(posedge ref_clk_i);
    #1 cmd_valid_i = 1'b0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 2000) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    if (n >= 2000) begin
      bad_count++;
      $display("answer timeout at %0t", $time);
    end
    r = {rsp_error_o, rsp_data_o};
  endtask
  function automatic logic [7:0] rd_exp(input logic [16:0] a);
    return shadow.exists(a) ? shadow[a] : 8'hff;
  endfunction
  function automatic logic [8:0] exp_prog(input logic [16:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = rd_exp(a) & d;
    shadow[a] = v;
    return {v !== d, v};
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    bad_count++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    logic [8:0]  r;
    logic [16:0] a;
    logic [7:0]  d;
    {cmd_valid_i, cmd_addr_i, cmd_data_i, bad_count, num_checks} = '0;
    cmd_i = otpc_pkg::OTPC_CMD_READ;
    sys_rst_i = 1'b1;
    void'($urandom(42459));
    repeat (6) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    // Corners first: last address, repeat on a used cell, odd slow cell
    for (int i = 0; i < 14; i++) begin
      a = (i == 0) ? otpc_pkg::ADDR_LAST : (i < 3) ? 17'h0_0001 : 17'($urandom);
      d = (i == 1) ? 8'h0f : (i == 2) ? 8'hf0 : 8'($urandom);
      do_cmd(otpc_pkg::OTPC_CMD_READ, a, 8'h00, r);
      check(r, {1'b0, rd_exp(a)});
      do_cmd(otpc_pkg::OTPC_CMD_PROG, a, d, r);
      check(r, exp_prog(a, d));
      do_cmd(otpc_pkg::OTPC_CMD_READ, a, 8'h00, r);
      check(r, {1'b0, rd_exp(a)});
    end
    $display("test program and read done");
    for (int b = 0; b < 4; b++) begin
      do_cmd(otpc_pkg::OTPC_CMD_IDENT, 17'(b), 8'h00, r);
      d = !b[1] ? CONT : b[0] ? TYPEB : MAKER;
      check(r, {1'b0, d});
      if (b[1]) check({8'h00, ^r[7:0]}, 9'h001);
    end
    $display("test identify done");
    // Code three must be ignored: no answer, select stays parked high
    repeat (10) @(posedge ref_clk_i);
    #1 cmd_i = otpc_pkg::OTPC_CMD_NONE;
    cmd_valid_i = 1'b1;
    repeat (12) begin
      @(posedge ref_clk_i);
      #1 cmd_valid_i = 1'b0;
      check({7'h00, rsp_valid_o, pins_o.dev_select_n}, 9'h001);
    end
    check({8'h00, cmd_ready_o}, 9'h001);
    $display("test ignored command done");
    test_done();
  end
endmodule
